// >>> design/dts_map.vh
`ifndef DTS_MAP_VH
`define DTS_MAP_VH

// register offsets
`define DTS_ADDR_MIN_CODE 16'h0100
`define DTS_ADDR_MAX_CODE 16'h0101
`define DTS_ADDR_LOW_BP 16'h0102
`define DTS_ADDR_HIGH_BP 16'h0103
`define DTS_ADDR_OVR_CTRL 16'h0109
`define DTS_ADDR_TARGET 16'h0110
`define DTS_ADDR_DUTY 16'h0111
`define DTS_OVR_FULL_BIT 2

// reset values
`define DTS_RST_MIN_CODE 8'h00
`define DTS_RST_MAX_CODE 8'hFF
`define DTS_RST_LOW_BP 8'h00
`define DTS_RST_HIGH_BP 8'hFF

// duty scale: full duty reads as this many counts
`define DTS_DUTY_FULL 8'hFF

// timing
`define DTS_SYS_CLK_HZ 50000000
`define DTS_CMD_FMIN_HZ 25
`define DTS_CMD_FMAX_HZ 100000
`define DTS_CMD_PERIOD_MAX_CYC (`DTS_SYS_CLK_HZ / `DTS_CMD_FMIN_HZ)
`define DTS_CMD_PERIOD_MIN_CYC (`DTS_SYS_CLK_HZ / `DTS_CMD_FMAX_HZ)
`define DTS_CMD_TIMEOUT_CYC (2 * `DTS_CMD_PERIOD_MAX_CYC)

// minimum-speed table segments: code start, rpm at start, rpm step
`define DTS_MIN_S1 8'h01
`define DTS_MIN_S1_RPM 16'h012C
`define DTS_MIN_S1_STEP 16'h000A
`define DTS_MIN_S2 8'h54
`define DTS_MIN_S2_RPM 16'h0474
`define DTS_MIN_S2_STEP 16'h0014
`define DTS_MIN_S3 8'h94
`define DTS_MIN_S3_RPM 16'h0992
`define DTS_MIN_S3_STEP 16'h0032
`define DTS_MIN_S4 8'hCC
`define DTS_MIN_S4_RPM 16'h14B4
`define DTS_MIN_S4_STEP 16'h0064

// maximum-speed table segments
`define DTS_MAX_S1_RPM 16'h012C
`define DTS_MAX_S1_STEP 16'h0014
`define DTS_MAX_S2 8'h2A
`define DTS_MAX_S2_RPM 16'h0488
`define DTS_MAX_S2_STEP 16'h0028
`define DTS_MAX_S3 8'h4A
`define DTS_MAX_S3_RPM 16'h09C4
`define DTS_MAX_S3_STEP 16'h0064
`define DTS_MAX_S4 8'h66
`define DTS_MAX_S4_RPM 16'h1518
`define DTS_MAX_S4_STEP 16'h00C8

`endif

// >>> design/dts_duty_meter.v
`timescale 1ns/10ps
`include "dts_map.vh"

module dts_duty_meter #(
  parameter TIMEOUT_CYC = `DTS_CMD_TIMEOUT_CYC,
  parameter CW = 22
) (
  input wire sys_clk,
  input wire reset,
  input wire cmdIn,
  output reg dutyValid,
  output reg [7:0] duty
);

  reg prevIn;
  reg seenRise;
  reg [CW-1:0] perCnt;
  reg [CW-1:0] highCnt;
  reg busy;
  reg [3:0] step;
  reg [CW+7:0] rem;
  reg [CW+7:0] den;
  reg [7:0] quot;
  wire rise = cmdIn & ~prevIn;
  wire timeout = (perCnt == TIMEOUT_CYC[CW-1:0]);
  wire fits = (rem >= den);

  // ----------------------------------------------------------
  // high time and period counting, then 8-step division
  // ----------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      prevIn <= 1'b0;
      seenRise <= 1'b0;
      perCnt <= {CW{1'b0}};
      highCnt <= {CW{1'b0}};
      busy <= 1'b0;
      step <= 4'h0;
      rem <= {(CW+8){1'b0}};
      den <= {(CW+8){1'b0}};
      quot <= 8'h00;
      dutyValid <= 1'b0;
      duty <= 8'h00;
    end else begin
      prevIn <= cmdIn;
      dutyValid <= 1'b0;
      if (rise || timeout) begin
        perCnt <= {{(CW-1){1'b0}}, 1'b1};
        highCnt <= {{(CW-1){1'b0}}, cmdIn};
      end else begin
        perCnt <= perCnt + {{(CW-1){1'b0}}, 1'b1};
        highCnt <= highCnt + {{(CW-1){1'b0}}, cmdIn};
      end
      if (timeout) begin
        // a still input is 0 % or 100 % duty
        seenRise <= 1'b0;
        busy <= 1'b0;
        duty <= cmdIn ? `DTS_DUTY_FULL : 8'h00;
        dutyValid <= 1'b1;
      end else if (rise) begin
        seenRise <= 1'b1;
        if (seenRise && !busy) begin
          // duty in counts = high * 255 / period  [RULE8] [RULE11]
          rem <= highCnt * `DTS_DUTY_FULL;
          den <= {1'b0, perCnt, 7'h00};
          quot <= 8'h00;
          step <= 4'h8;
          busy <= 1'b1;
        end
      end
      if (busy && !timeout) begin
        if (fits) begin
          rem <= rem - den;
        end
        quot <= {quot[6:0], fits};
        den <= den >> 1;
        step <= step - 4'h1;
        if (step == 4'h1) begin
          busy <= 1'b0;
          duty <= {quot[6:0], fits};
          dutyValid <= 1'b1;
        end
      end
    end
  end

endmodule

// >>> design/dts_speed_target.v
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`include "dts_map.vh"

// How it works
// RULE1: lower breakpoint gives minimum-speed target, upper breakpoint gives maximum-speed target.
// RULE2: minimum-speed code decodes by fixed table: 0 rpm, 300 rpm, up to 10400.
// RULE3: maximum-speed code decodes by fixed table from 300 to 36000 rpm.
// RULE4: each breakpoint means value over 255 of full input duty.
// RULE5: between breakpoints, target speed interpolates linearly between the two end points.
// RULE6: software keeps maximum-speed setting not below minimum-speed setting.
// RULE7: software keeps upper breakpoint not below lower breakpoint.
// RULE8: command input is 25 Hz to 100 kHz; any such rate is measured.
// RULE9: four settings sit in bits 7:0 at 0x0100 to 0x0103.
// RULE10: above upper breakpoint hold maximum target, or full output duty when selected.
// RULE11: input duty is measured in 255 counts and compared with both breakpoints.
module dts_speed_target #(
  parameter TIMEOUT_CYC = `DTS_CMD_TIMEOUT_CYC
) (
  input wire sys_clk,
  input wire reset,
  input wire cmdIn,
  input wire [15:0] addr,
  input wire [15:0] writeData,
  input wire writeStrobe,
  input wire readStrobe,
  output reg [15:0] readData,
  output reg [15:0] targetRpm,
  output reg targetValid,
  output reg fullDuty
);

  localparam ST_IDLE = 2'b00;
  localparam ST_DIV = 2'b01;
  localparam ST_DONE = 2'b10;

  reg [7:0] minSpeedCode;
  reg [7:0] maxSpeedCode;
  reg [7:0] lowDutyBreakpoint;
  reg [7:0] highDutyBreakpoint;
  reg fullSelect;
  reg [7:0] dutyNow;
  reg [1:0] state;
  reg [4:0] step;
  reg [15:0] baseRpm;
  reg [23:0] rem;
  reg [23:0] den;
  reg [15:0] quot;
  wire dutyValid;
  wire [7:0] dutyMeas;
  wire [15:0] minRpm;
  wire [15:0] maxRpm;
  wire fits = (rem >= den);

  // ----------------------------------------------------------
  // code to rpm tables, held as their linear segments
  // ----------------------------------------------------------
  function [15:0] seg;
    input [7:0] code;
    input [7:0] start;
    input [15:0] rpm0;
    input [15:0] stepRpm;
    reg [23:0] prod;
    begin
      prod = (code - start) * stepRpm;
      seg = rpm0 + prod[15:0];
    end
  endfunction

  function [15:0] decodeMin;
    input [7:0] code;
    begin
      if (code < `DTS_MIN_S1)
        decodeMin = 16'h0000;
      else if (code < `DTS_MIN_S2)
        decodeMin = seg(code, `DTS_MIN_S1, `DTS_MIN_S1_RPM, `DTS_MIN_S1_STEP);
      else if (code < `DTS_MIN_S3)
        decodeMin = seg(code, `DTS_MIN_S2, `DTS_MIN_S2_RPM, `DTS_MIN_S2_STEP);
      else if (code < `DTS_MIN_S4)
        decodeMin = seg(code, `DTS_MIN_S3, `DTS_MIN_S3_RPM, `DTS_MIN_S3_STEP);
      else
        decodeMin = seg(code, `DTS_MIN_S4, `DTS_MIN_S4_RPM, `DTS_MIN_S4_STEP);
    end
  endfunction

  function [15:0] decodeMax;
    input [7:0] code;
    begin
      if (code < `DTS_MAX_S2)
        decodeMax = seg(code, 8'h00, `DTS_MAX_S1_RPM, `DTS_MAX_S1_STEP);
      else if (code < `DTS_MAX_S3)
        decodeMax = seg(code, `DTS_MAX_S2, `DTS_MAX_S2_RPM, `DTS_MAX_S2_STEP);
      else if (code < `DTS_MAX_S4)
        decodeMax = seg(code, `DTS_MAX_S3, `DTS_MAX_S3_RPM, `DTS_MAX_S3_STEP);
      else
        decodeMax = seg(code, `DTS_MAX_S4, `DTS_MAX_S4_RPM, `DTS_MAX_S4_STEP);
    end
  endfunction

  assign minRpm = decodeMin(minSpeedCode); // [RULE2]
  assign maxRpm = decodeMax(maxSpeedCode); // [RULE3]

  // ----------------------------------------------------------
  // duty measurement of the command input
  // ----------------------------------------------------------
  dts_duty_meter #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) meter (
    .sys_clk(sys_clk),
    .reset(reset),
    .cmdIn(cmdIn),
    .dutyValid(dutyValid),
    .duty(dutyMeas)
  );

  // ----------------------------------------------------------
  // register port
  // ----------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      minSpeedCode <= `DTS_RST_MIN_CODE;
      maxSpeedCode <= `DTS_RST_MAX_CODE;
      lowDutyBreakpoint <= `DTS_RST_LOW_BP;
      highDutyBreakpoint <= `DTS_RST_HIGH_BP;
      fullSelect <= 1'b0;
      readData <= 16'h0000;
    end else begin
      if (writeStrobe) begin
        case (addr)
          `DTS_ADDR_MIN_CODE: minSpeedCode <= writeData[7:0]; // [RULE9]
          `DTS_ADDR_MAX_CODE: maxSpeedCode <= writeData[7:0]; // [RULE9]
          `DTS_ADDR_LOW_BP: lowDutyBreakpoint <= writeData[7:0]; // [RULE9]
          `DTS_ADDR_HIGH_BP: highDutyBreakpoint <= writeData[7:0]; // [RULE9]
          `DTS_ADDR_OVR_CTRL: fullSelect <= writeData[`DTS_OVR_FULL_BIT];
          default: fullSelect <= fullSelect;
        endcase
      end
      readData <= 16'h0000;
      if (readStrobe) begin
        case (addr)
          `DTS_ADDR_MIN_CODE: readData <= {8'h00, minSpeedCode};
          `DTS_ADDR_MAX_CODE: readData <= {8'h00, maxSpeedCode};
          `DTS_ADDR_LOW_BP: readData <= {8'h00, lowDutyBreakpoint};
          `DTS_ADDR_HIGH_BP: readData <= {8'h00, highDutyBreakpoint};
          `DTS_ADDR_OVR_CTRL: readData <= {13'h0000, fullSelect, 2'b00};
          `DTS_ADDR_TARGET: readData <= targetRpm;
          `DTS_ADDR_DUTY: readData <= {8'h00, dutyNow};
          default: readData <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------
  // target speed from measured duty
  // ----------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      state <= ST_IDLE;
      dutyNow <= 8'h00;
      step <= 5'h00;
      baseRpm <= 16'h0000;
      rem <= 24'h000000;
      den <= 24'h000000;
      quot <= 16'h0000;
      targetRpm <= 16'h0000;
      targetValid <= 1'b0;
      fullDuty <= 1'b0;
    end else begin
      targetValid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (dutyValid) begin
            dutyNow <= dutyMeas;
            // compare in the breakpoints' own 255-count scale  [RULE4] [RULE11]
            if (dutyMeas <= lowDutyBreakpoint) begin
              targetRpm <= minRpm; // [RULE1]
              fullDuty <= 1'b0;
              targetValid <= 1'b1;
            end else if (dutyMeas >= highDutyBreakpoint) begin
              targetRpm <= maxRpm; // [RULE1] [RULE10]
              fullDuty <= fullSelect && (dutyMeas > highDutyBreakpoint); // [RULE10]
              targetValid <= 1'b1;
            end else begin
              // min + (max - min) * (d - dl) / (dh - dl)  [RULE5]
              baseRpm <= minRpm;
              rem <= (maxRpm - minRpm) * (dutyMeas - lowDutyBreakpoint);
              den <= {1'b0, highDutyBreakpoint - lowDutyBreakpoint, 15'h0000};
              quot <= 16'h0000;
              step <= 5'h10;
              state <= ST_DIV;
            end
          end
        end
        ST_DIV: begin
          if (fits) begin
            rem <= rem - den;
          end
          quot <= {quot[14:0], fits};
          den <= den >> 1;
          step <= step - 5'h01;
          if (step == 5'h01) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          targetRpm <= baseRpm + quot; // [RULE5]
          fullDuty <= 1'b0;
          targetValid <= 1'b1;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule

// >>> tb/dts_speed_checker.sv
`timescale 1ns/10ps
`include "dts_map.vh"
module dts_speed_checker #(
  parameter TIMEOUT_CYC = 2000
) (
  input wire sys_clk,
  input wire reset,
  input wire cmdIn,
  input wire [15:0] addr,
  input wire [15:0] writeData,
  input wire writeStrobe,
  input wire readStrobe,
  input wire [15:0] readData,
  input wire [15:0] targetRpm,
  input wire targetValid,
  input wire fullDuty
);
  // ----------------------------------------
  // shadow of the settings
  // ----------------------------------------
  reg [7:0] minC;
  reg [7:0] maxC;
  reg [7:0] lowBp;
  reg [7:0] highBp;
  reg fullSel;
  always @(posedge sys_clk) begin
    if (reset) begin
      minC <= `DTS_RST_MIN_CODE;
      maxC <= `DTS_RST_MAX_CODE;
      lowBp <= `DTS_RST_LOW_BP;
      highBp <= `DTS_RST_HIGH_BP;
      fullSel <= 1'b0;
    end else if (writeStrobe) begin
      if (addr == `DTS_ADDR_MIN_CODE) minC <= writeData[7:0];
      if (addr == `DTS_ADDR_MAX_CODE) maxC <= writeData[7:0];
      if (addr == `DTS_ADDR_LOW_BP) lowBp <= writeData[7:0];
      if (addr == `DTS_ADDR_HIGH_BP) highBp <= writeData[7:0];
      if (addr == `DTS_ADDR_OVR_CTRL) fullSel <= writeData[`DTS_OVR_FULL_BIT];
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence rdAt(a);
    readStrobe && addr == a;
  endsequence
  rd_idle_a: assert property (!readStrobe |=> readData == 16'h0000)
    else $error("read data not cleared");
  rd_min_a: assert property (rdAt(`DTS_ADDR_MIN_CODE) |=> readData == {8'h00, minC})
    else $error("minimum code readback wrong");
  rd_max_a: assert property (rdAt(`DTS_ADDR_MAX_CODE) |=> readData == {8'h00, maxC})
    else $error("maximum code readback wrong");
  rd_lowbp_a: assert property (rdAt(`DTS_ADDR_LOW_BP) |=> readData == {8'h00, lowBp})
    else $error("low breakpoint readback wrong");
  rd_highbp_a: assert property (rdAt(`DTS_ADDR_HIGH_BP) |=> readData == {8'h00, highBp})
    else $error("high breakpoint readback wrong");
  rd_target_a: assert property (rdAt(`DTS_ADDR_TARGET) |=> readData == $past(targetRpm))
    else $error("target readback wrong");
  valid_pulse_a: assert property (targetValid |=> !targetValid)
    else $error("target valid longer than one cycle");
  target_hold_a: assert property (!targetValid |-> $stable(targetRpm) && $stable(fullDuty))
    else $error("target changed without valid");
  full_sel_a: assert property ($rose(fullDuty) |-> $past(fullSel) && targetValid)
    else $error("full duty without over-range select");
endmodule
bind dts_speed_target dts_speed_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_i (.sys_clk(sys_clk), .reset(reset),
  .cmdIn(cmdIn), .addr(addr), .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
  .readData(readData), .targetRpm(targetRpm), .targetValid(targetValid), .fullDuty(fullDuty));

// >>> tb/dts_cmd_host.sv
`timescale 1ns/10ps
module dts_cmd_host (
  input wire sys_clk,
  input wire [31:0] period,
  input wire [31:0] highCyc,
  output reg cmdIn
);
  // ----------------------------------------
  // free-running duty generator
  // ----------------------------------------
  reg [31:0] cnt;
  initial cnt = 32'h0;
  initial cmdIn = 1'b0;
  always @(posedge sys_clk) begin
    cnt <= (cnt + 32'h1 >= period) ? 32'h0 : cnt + 32'h1;
    cmdIn <= (cnt < highCyc);
  end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/10ps
`include "dts_map.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; $display("unexpected %0t %h %h", $time, g, e); end end
module testbench;
  reg sys_clk = 1'b0;
  reg reset = 1'b1;
  reg [15:0] addr = 16'h0000;
  reg [15:0] writeData = 16'h0000;
  reg writeStrobe = 1'b0;
  reg readStrobe = 1'b0;
  reg [31:0] period = 32'd500;
  reg [31:0] highCyc = 32'd1;
  wire cmdIn;
  wire [15:0] readData;
  wire [15:0] targetRpm;
  wire targetValid;
  wire fullDuty;
  int n_errors = 0;
  int compares = 0;
  always #10 sys_clk = ~sys_clk;
  dts_cmd_host dts_cmd_host_i (.sys_clk(sys_clk), .period(period), .highCyc(highCyc), .cmdIn(cmdIn));
  dts_speed_target #(.TIMEOUT_CYC(2000)) dts_speed_target_i (.sys_clk(sys_clk), .reset(reset), .cmdIn(cmdIn),
    .addr(addr), .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
    .targetRpm(targetRpm), .targetValid(targetValid), .fullDuty(fullDuty));
  task finish_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wr(input [15:0] a, input [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge sys_clk);
    writeStrobe <= 1'b0;
  endtask
  task rd(input [15:0] a, input [15:0] e);
    @(posedge sys_clk);
    addr <= a;
    readStrobe <= 1'b1;
    @(posedge sys_clk);
    readStrobe <= 1'b0;
    @(negedge sys_clk);
    `CHK(readData, e)
  endtask
  // skips updates that may mix old and new duty
  task point(input [31:0] h, input [15:0] e, input f);
    int n;
    int k;
    n = 3;
    k = 0;
    @(posedge sys_clk);
    highCyc <= h;
    while (n > 0 && k < 8000) begin
      @(negedge sys_clk);
      k++;
      if (targetValid === 1'b1) n--;
    end
    if (n > 0) begin
      n_errors++;
      finish_test();
    end else begin
      `CHK(targetRpm, e)
      `CHK(fullDuty, f)
    end
  endtask
  task t_regs;
    rd(`DTS_ADDR_MIN_CODE, 16'h0000);
    rd(`DTS_ADDR_MAX_CODE, 16'h00FF);
    rd(`DTS_ADDR_LOW_BP, 16'h0000);
    rd(`DTS_ADDR_HIGH_BP, 16'h00FF);
    rd(16'h0104, 16'h0000);
    rd(`DTS_ADDR_OVR_CTRL, 16'h0000);
    wr(`DTS_ADDR_LOW_BP, 16'hAB40);
    rd(`DTS_ADDR_LOW_BP, 16'h0040);
    wr(`DTS_ADDR_LOW_BP, 16'h0000);
  endtask
  task t_tables;
    wr(`DTS_ADDR_MIN_CODE, 16'h0000);
    wr(`DTS_ADDR_HIGH_BP, 16'h00FE);
    point(1, 16'h0000, 1'b0);
    wr(`DTS_ADDR_MIN_CODE, 16'h0001);
    point(1, 16'h012C, 1'b0);
    point(499, 16'h8CA0, 1'b0);
    wr(`DTS_ADDR_MAX_CODE, 16'h0000);
    point(499, 16'h012C, 1'b0);
  endtask
  task t_curve;
    wr(`DTS_ADDR_MIN_CODE, 16'h0054);
    wr(`DTS_ADDR_MAX_CODE, 16'h004A);
    wr(`DTS_ADDR_LOW_BP, 16'h0040);
    wr(`DTS_ADDR_HIGH_BP, 16'h00C0);
    point(100, 16'h0474, 1'b0);
    rd(`DTS_ADDR_DUTY, 16'h0033);
    point(126, 16'h0474, 1'b0);
    point(250, 16'h0711, 1'b0);
    rd(`DTS_ADDR_TARGET, 16'h0711);
    point(377, 16'h09C4, 1'b0);
    point(450, 16'h09C4, 1'b0);
    wr(`DTS_ADDR_OVR_CTRL, 16'h0004);
    rd(`DTS_ADDR_OVR_CTRL, 16'h0004);
    point(450, 16'h09C4, 1'b1);
    point(377, 16'h09C4, 1'b0);
  endtask
  task t_rate;
    @(posedge sys_clk);
    period <= 32'd1500;
    point(750, 16'h0711, 1'b0);
    // a still high input times out as full duty, a still low one as zero
    point(1500, 16'h09C4, 1'b1);
    rd(`DTS_ADDR_DUTY, 16'h00FF);
    point(0, 16'h0474, 1'b0);
    rd(`DTS_ADDR_DUTY, 16'h0000);
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs;
    t_tables;
    t_curve;
    t_rate;
    finish_test;
  end
endmodule
